// ===== ppc_loop_ctrl.sv
// module: closed-loop process control decision, deviation and status outputs
`timescale 1ns/1ps
module ppc_loop_ctrl
  import ppc_pkg::*;
#(
  parameter logic        LOOP_A_REVERSE = 1'b1,
  parameter int          TICK_CYC       = PPC_TICK_CYC
)
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire ppc_cfg_t    cfg_in,
  input  wire logic [39:0] input_function_settings_in,
  input  wire logic [4:0]  input_terminal_in,
  input  wire logic [4:0]  net_terminal_in,
  input  wire logic        net_control_in,
  input  wire logic [15:0] terminal2_adc_in,
  input  wire logic [15:0] terminal4_adc_in,
  input  wire logic [15:0] output_freq_in,
  input  wire logic        forward_indication_in,
  input  wire logic        reverse_indication_in,
  input  wire logic        run_request_in,
  input  wire logic [7:0]  output_function_setting_a_in,
  input  wire logic [7:0]  output_function_setting_b_in,
  input  wire logic [7:0]  output_function_setting_c_in,
  output logic signed [31:0] manipulated_out,
  output logic signed [16:0] deviation_out,
  output logic [15:0]      setpoint_pct_out,
  output logic [15:0]      measured_pct_out,
  output logic             loop_in_effect_out,
  output logic             running_out,
  output logic             upper_limit_flag_out,
  output logic             lower_limit_flag_out,
  output logic             rotation_direction_output_out,
  output logic             loop_active_output_out,
  output logic             suspend_indicator_out,
  output logic [2:0]       terminal_out
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [15:0] scale_pct(input logic [15:0] raw, input logic [15:0] lo,
                                            input logic [15:0] full);
    logic [31:0] num;
    num = 32'(raw - lo) * 32'(PPC_PCT_FULL);
    if (raw <= lo)
      scale_pct = 16'h0000;
    else if (raw >= full)
      scale_pct = PPC_PCT_FULL;
    else
      scale_pct = 16'(num / 32'(full - lo));
  endfunction : scale_pct

  function automatic logic not_sentinel(input logic [15:0] v);
    not_sentinel = (v != PPC_SENTINEL);
  endfunction : not_sentinel

  // ==========================================================================
  // enable decision
  // ==========================================================================
  logic       loop_code;
  logic       sel_assigned;
  logic       sel_on;
  logic       loop_enable;
  logic       reverse_mode;

  always_comb
  begin
    sel_assigned = 1'b0;
    sel_on       = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      if (input_function_settings_in[i*8 +: 8] == PPC_IN_LOOPSEL)
      begin
        sel_assigned = 1'b1;
        sel_on = sel_on | (net_control_in ? net_terminal_in[i] : input_terminal_in[i]);
      end
    end
  end

  assign loop_code   = (cfg_in.action_select_setting == PPC_ACT_LOOP_A) ||
                       (cfg_in.action_select_setting == PPC_ACT_LOOP_B);
  assign loop_enable = loop_code && (!sel_assigned || sel_on);
  assign reverse_mode = (cfg_in.action_select_setting == PPC_ACT_LOOP_A) ?
                        LOOP_A_REVERSE : ~LOOP_A_REVERSE;

  // ==========================================================================
  // set point and measured value
  // ==========================================================================
  logic [15:0] sp_nxt;
  logic [15:0] mv_nxt;
  logic [15:0] sp_ff;
  logic [15:0] mv_ff;
  logic [15:0] half_full;

  assign half_full = 16'(PPC_ADC_FULL >> 1);

  always_comb
  begin
    if (not_sentinel(cfg_in.stored_setpoint_value))
      sp_nxt = cfg_in.stored_setpoint_value;
    else if (not_sentinel(cfg_in.thermistor_protection_level))
      sp_nxt = 16'h0000;
    else if (cfg_in.setpoint_range_setting == PPC_SP_5V_A ||
             cfg_in.setpoint_range_setting == PPC_SP_5V_B)
      sp_nxt = scale_pct(terminal2_adc_in, 16'h0000, half_full);
    else
      sp_nxt = scale_pct(terminal2_adc_in, 16'h0000, PPC_ADC_FULL);
  end

  always_comb
  begin
    case (cfg_in.measured_range_setting)
      PPC_MV_4_20MA: mv_nxt = scale_pct(terminal4_adc_in, PPC_ADC_LIVE0, PPC_ADC_FULL);
      PPC_MV_5V:     mv_nxt = scale_pct(terminal4_adc_in, 16'h0000, half_full);
      PPC_MV_10V:    mv_nxt = scale_pct(terminal4_adc_in, 16'h0000, PPC_ADC_FULL);
      default:       mv_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sp_ff <= 16'h0000;
      mv_ff <= 16'h0000;
    end
    else
    begin
      sp_ff <= sp_nxt;
      mv_ff <= mv_nxt;
    end
  end

  // ==========================================================================
  // deviation and pid terms
  // ==========================================================================
  logic signed [16:0] dev_ff;
  logic signed [16:0] dev_prev_ff;
  logic signed [31:0] integ_ff;
  logic signed [31:0] mv_out_ff;
  logic signed [16:0] err;
  logic signed [31:0] p_term;
  logic signed [31:0] d_term;
  logic               tick;

  // deviation is set point minus measured; forward action flips its sign
  assign err    = reverse_mode ? dev_ff : -dev_ff;
  assign p_term = 32'(err * $signed({1'b0, cfg_in.gain_p}));
  assign d_term = 32'((dev_ff - dev_prev_ff) * $signed({1'b0, cfg_in.gain_d}));

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      dev_ff      <= 17'sh0;
      dev_prev_ff <= 17'sh0;
    end
    else
    begin
      dev_ff <= $signed({1'b0, sp_ff}) - $signed({1'b0, mv_ff});
      if (tick)
        dev_prev_ff <= dev_ff;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      integ_ff  <= 32'sh0;
      mv_out_ff <= 32'sh0;
    end
    else if (!loop_enable)
    begin
      integ_ff  <= 32'sh0;
      mv_out_ff <= 32'sh0;
    end
    else if (tick)
    begin
      integ_ff  <= integ_ff + 32'(err * $signed({1'b0, cfg_in.gain_i}));
      mv_out_ff <= p_term + integ_ff + (reverse_mode ? d_term : -d_term);
    end
  end

  // ==========================================================================
  // millisecond tick
  // ==========================================================================
  logic [31:0] tick_cnt_ff;

  assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || tick)
      tick_cnt_ff <= 32'h0;
    else
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
  end

  // ==========================================================================
  // operating state
  // ==========================================================================
  ppc_state_t  state_ff;
  ppc_state_t  nxt_state;
  logic [31:0] low_ms_ff;
  logic        susp_allowed;
  logic        freq_low;
  logic [31:0] limit_ms;

  assign susp_allowed = not_sentinel(cfg_in.suspend_detection_time);
  assign freq_low     = output_freq_in < cfg_in.suspend_frequency_level;
  assign limit_ms     = 32'(cfg_in.suspend_detection_time) * 32'(PPC_MS_PER_TS);

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || state_ff != PPC_ST_LOOP || !freq_low)
      low_ms_ff <= 32'h0;
    else if (tick && low_ms_ff <= limit_ms)
      low_ms_ff <= low_ms_ff + 32'h1;
  end

  always_comb
  begin
    case (state_ff)
      PPC_ST_NORMAL:  nxt_state = loop_enable ? PPC_ST_LOOP : PPC_ST_NORMAL;
      PPC_ST_LOOP:
        if (!loop_enable)
          nxt_state = PPC_ST_NORMAL;
        else if (susp_allowed && low_ms_ff > limit_ms)
          nxt_state = PPC_ST_SUSPEND;
        else
          nxt_state = PPC_ST_LOOP;
      PPC_ST_SUSPEND:
        if (!loop_enable)
          nxt_state = PPC_ST_NORMAL;
        else if (!susp_allowed || !freq_low)
          nxt_state = PPC_ST_LOOP;
        else
          nxt_state = PPC_ST_SUSPEND;
      default:        nxt_state = PPC_ST_NORMAL;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      state_ff <= PPC_ST_NORMAL;
    else
      state_ff <= nxt_state;
  end

  // ==========================================================================
  // status flags
  // ==========================================================================
  ppc_flags_t flags_ff;
  logic       run_ff;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      flags_ff <= '0;
      run_ff   <= 1'b0;
    end
    else
    begin
      flags_ff.upper_limit_flag <= loop_code && not_sentinel(cfg_in.upper_limit_setting) &&
                                   (mv_ff > cfg_in.upper_limit_setting);
      flags_ff.lower_limit_flag <= loop_code && not_sentinel(cfg_in.lower_limit_setting) &&
                                   (mv_ff < cfg_in.lower_limit_setting);
      flags_ff.rotation_direction_output <= forward_indication_in &&
                                            !reverse_indication_in;
      flags_ff.loop_active_output <= (nxt_state != PPC_ST_NORMAL);
      flags_ff.suspend_indicator  <= (nxt_state == PPC_ST_SUSPEND);
      run_ff <= run_request_in && (nxt_state != PPC_ST_SUSPEND);
    end
  end

  ppc_term_map u_term_map (
    .ref_clk_in                   (ref_clk_in),
    .rst_in                       (rst_in),
    .flags_in                     (flags_ff),
    .output_function_setting_a_in (output_function_setting_a_in),
    .output_function_setting_b_in (output_function_setting_b_in),
    .output_function_setting_c_in (output_function_setting_c_in),
    .terminal_out                 (terminal_out)
  );

  assign manipulated_out               = mv_out_ff;
  assign deviation_out                 = dev_ff;
  assign setpoint_pct_out              = sp_ff;
  assign measured_pct_out              = mv_ff;
  assign loop_in_effect_out            = flags_ff.loop_active_output;
  assign running_out                   = run_ff;
  assign upper_limit_flag_out          = flags_ff.upper_limit_flag;
  assign lower_limit_flag_out          = flags_ff.lower_limit_flag;
  assign rotation_direction_output_out = flags_ff.rotation_direction_output;
  assign loop_active_output_out        = flags_ff.loop_active_output;
  assign suspend_indicator_out         = flags_ff.suspend_indicator;

endmodule : ppc_loop_ctrl

// ===== ppc_loop_sva.sv
// checker: port assertions for the process loop control block
`timescale 1ns/1ps
module ppc_loop_sva
  import ppc_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire ppc_cfg_t    cfg_in,
  input wire logic [39:0] input_function_settings_in,
  input wire logic [4:0]  input_terminal_in,
  input wire logic [4:0]  net_terminal_in,
  input wire logic        net_control_in,
  input wire logic        forward_indication_in,
  input wire logic [7:0]  output_function_setting_a_in,
  input wire logic [7:0]  output_function_setting_b_in,
  input wire logic [7:0]  output_function_setting_c_in,
  input wire logic [15:0] measured_pct_out,
  input wire logic        running_out,
  input wire logic        upper_limit_flag_out,
  input wire logic        lower_limit_flag_out,
  input wire logic        rotation_direction_output_out,
  input wire logic        loop_active_output_out,
  input wire logic        suspend_indicator_out,
  input wire logic [2:0]  terminal_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // =====
  // expected levels
  logic       act_loop;
  logic       sel_ok;
  logic       up_c;
  logic       lo_c;
  logic [4:0] sel_asg;
  logic [2:0] exp_t;
  ppc_flags_t fl;

  function automatic logic tmap(input logic [7:0] c, input ppc_flags_t f);
    logic       inv;
    logic [7:0] b;
    inv = (c >= PPC_NEG_BASE);
    b   = inv ? c - PPC_NEG_BASE : c;
    case (b)
      PPC_OUT_LOWER:  return inv ^ f.lower_limit_flag;
      PPC_OUT_UPPER:  return inv ^ f.upper_limit_flag;
      PPC_OUT_DIR:    return inv ^ f.rotation_direction_output;
      PPC_OUT_ACTIVE: return inv ^ f.loop_active_output;
      PPC_OUT_SUSP:   return inv ^ f.suspend_indicator;
      default:        return inv;
    endcase
  endfunction : tmap

  always_comb
  begin
    for (int i = 0; i < 5; i++)
      sel_asg[i] = (input_function_settings_in[8*i +: 8] == PPC_IN_LOOPSEL);
  end
  assign act_loop = (cfg_in.action_select_setting == PPC_ACT_LOOP_A)
                 || (cfg_in.action_select_setting == PPC_ACT_LOOP_B);
  assign sel_ok = !(|sel_asg)
               || |(sel_asg & (net_control_in ? net_terminal_in : input_terminal_in));
  assign up_c = act_loop && cfg_in.upper_limit_setting != PPC_SENTINEL
             && measured_pct_out > cfg_in.upper_limit_setting;
  assign lo_c = act_loop && cfg_in.lower_limit_setting != PPC_SENTINEL
             && measured_pct_out < cfg_in.lower_limit_setting;
  assign fl = {upper_limit_flag_out, lower_limit_flag_out, rotation_direction_output_out,
               loop_active_output_out, suspend_indicator_out};
  assign exp_t = {tmap(output_function_setting_c_in, fl), tmap(output_function_setting_b_in, fl),
                  tmap(output_function_setting_a_in, fl)};
  // =====
  // assertions
  property p_loop_off;
    (!act_loop) [*3] |-> !loop_active_output_out;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loop on without code");
  property p_sel_off;
    (act_loop && !sel_ok) [*3] |-> !loop_active_output_out;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("loop on with select off");
  property p_loop_on;
    (act_loop && sel_ok) [*3] |-> loop_active_output_out;
  endproperty
  a_loop_on: assert property (p_loop_on) else $error("loop not active");
  property p_sleep;
    suspend_indicator_out [*2] |-> !running_out && loop_active_output_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad indicators in suspend");
  property p_no_sleep;
    (cfg_in.suspend_detection_time == PPC_SENTINEL) [*4] |-> !suspend_indicator_out;
  endproperty
  a_no_sleep: assert property (p_no_sleep) else $error("suspend with sentinel");
  property p_upper;
    $stable(up_c) [*4] |-> upper_limit_flag_out == up_c;
  endproperty
  a_upper: assert property (p_upper) else $error("upper flag wrong");
  property p_lower;
    $stable(lo_c) [*4] |-> lower_limit_flag_out == lo_c;
  endproperty
  a_lower: assert property (p_lower) else $error("lower flag wrong");
  property p_dir;
    $stable(forward_indication_in) [*4] |-> rotation_direction_output_out == forward_indication_in;
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_term;
    $stable(exp_t) [*3] |-> terminal_out == exp_t;
  endproperty
  a_term: assert property (p_term) else $error("terminal level wrong");
endmodule : ppc_loop_sva

bind ppc_loop_ctrl ppc_loop_sva i_sva (.*);

// ===== ppc_pkg.sv
// package: constants, codes and carrier types for the process loop control block
package ppc_pkg;

  // ==========================================================================
  // widths and sentinel
  // ==========================================================================
  localparam int          PPC_SET_W      = 16;
  localparam int          PPC_PCT_W      = 16;
  localparam logic [15:0] PPC_SENTINEL   = 16'h270f;
  localparam logic [15:0] PPC_PCT_FULL   = 16'h03e8;
  localparam logic [15:0] PPC_ADC_FULL   = 16'h0fff;
  localparam logic [15:0] PPC_ADC_LIVE0  = 16'h0333;

  // ==========================================================================
  // action select codes
  // ==========================================================================
  localparam logic [7:0]  PPC_ACT_OFF    = 8'h00;
  localparam logic [7:0]  PPC_ACT_LOOP_A = 8'h14;
  localparam logic [7:0]  PPC_ACT_LOOP_B = 8'h15;

  // ==========================================================================
  // terminal function codes
  // ==========================================================================
  localparam logic [7:0]  PPC_IN_LOOPSEL = 8'h0e;
  localparam logic [7:0]  PPC_OUT_LOWER  = 8'h0e;
  localparam logic [7:0]  PPC_OUT_UPPER  = 8'h0f;
  localparam logic [7:0]  PPC_OUT_DIR    = 8'h10;
  localparam logic [7:0]  PPC_OUT_ACTIVE = 8'h2f;
  localparam logic [7:0]  PPC_OUT_SUSP   = 8'h46;
  localparam logic [7:0]  PPC_NEG_BASE   = 8'h64;

  // ==========================================================================
  // analog range settings
  // ==========================================================================
  localparam logic [7:0]  PPC_SP_10V_A   = 8'h00;
  localparam logic [7:0]  PPC_SP_5V_A    = 8'h01;
  localparam logic [7:0]  PPC_SP_10V_B   = 8'h0a;
  localparam logic [7:0]  PPC_SP_5V_B    = 8'h0b;
  localparam logic [7:0]  PPC_MV_4_20MA  = 8'h00;
  localparam logic [7:0]  PPC_MV_5V      = 8'h01;
  localparam logic [7:0]  PPC_MV_10V     = 8'h02;

  // ==========================================================================
  // timing: one tick per ms drives the suspend timer
  // ==========================================================================
  localparam int          PPC_CLK_HZ     = 125000000;
  localparam int          PPC_TICK_US    = 1000;
  localparam int          PPC_TICK_CYC   = PPC_CLK_HZ / 1000000 * PPC_TICK_US;
  localparam logic [15:0] PPC_MS_PER_TS  = 16'h0064;

  // ==========================================================================
  // carrier types
  // ==========================================================================
  typedef struct packed {
    logic [7:0]  action_select_setting;
    logic [15:0] stored_setpoint_value;
    logic [15:0] upper_limit_setting;
    logic [15:0] lower_limit_setting;
    logic [7:0]  setpoint_range_setting;
    logic [7:0]  measured_range_setting;
    logic [15:0] suspend_detection_time;
    logic [15:0] suspend_frequency_level;
    logic [15:0] thermistor_protection_level;
    logic [15:0] gain_p;
    logic [15:0] gain_i;
    logic [15:0] gain_d;
  } ppc_cfg_t;

  typedef struct packed {
    logic upper_limit_flag;
    logic lower_limit_flag;
    logic rotation_direction_output;
    logic loop_active_output;
    logic suspend_indicator;
  } ppc_flags_t;

  typedef enum logic [2:0] {
    PPC_ST_NORMAL  = 3'b001,
    PPC_ST_LOOP    = 3'b010,
    PPC_ST_SUSPEND = 3'b100
  } ppc_state_t;

endpackage : ppc_pkg

// ===== ppc_sense_model.sv
// model: process detector and set point source on the analog terminals
`timescale 1ns/1ps
module ppc_sense_model
  import ppc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic [15:0] sp_pct_in,
  input  wire logic [15:0] mv_pct_in,
  input  wire logic        mv_current_in,
  output logic      [15:0] terminal2_adc_out = 16'h0000,
  output logic      [15:0] terminal4_adc_out = 16'h0000
);
  // current loop has a live zero, voltage inputs start at 0
  always @(posedge ref_clk_in)
  begin
    terminal2_adc_out <= 16'(32'(sp_pct_in) * PPC_ADC_FULL / PPC_PCT_FULL);
    terminal4_adc_out <= mv_current_in
      ? 16'(PPC_ADC_LIVE0 + 32'(mv_pct_in) * (PPC_ADC_FULL - PPC_ADC_LIVE0) / PPC_PCT_FULL)
      : 16'(32'(mv_pct_in) * PPC_ADC_FULL / PPC_PCT_FULL);
  end
endmodule : ppc_sense_model

// ===== ppc_term_map.sv
// module: maps status flags onto three open-collector terminals with polarity
`timescale 1ns/1ps
module ppc_term_map
  import ppc_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire ppc_flags_t flags_in,
  input  wire logic [7:0] output_function_setting_a_in,
  input  wire logic [7:0] output_function_setting_b_in,
  input  wire logic [7:0] output_function_setting_c_in,
  output logic      [2:0] terminal_out
);

  // ==========================================================================
  // code to flag lookup
  // ==========================================================================
  function automatic logic term_level(input logic [7:0] code, input ppc_flags_t f);
    logic [7:0] base;
    logic       lvl;
    base = (code >= PPC_NEG_BASE) ? 8'(code - PPC_NEG_BASE) : code;
    case (base)
      PPC_OUT_UPPER:  lvl = f.upper_limit_flag;
      PPC_OUT_LOWER:  lvl = f.lower_limit_flag;
      PPC_OUT_DIR:    lvl = f.rotation_direction_output;
      PPC_OUT_ACTIVE: lvl = f.loop_active_output;
      PPC_OUT_SUSP:   lvl = f.suspend_indicator;
      default:        lvl = 1'b0;
    endcase
    term_level = (code >= PPC_NEG_BASE) ? ~lvl : lvl;
  endfunction : term_level

  logic [2:0] term_ff;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      term_ff <= 3'h0;
    end
    else
    begin
      term_ff[0] <= term_level(output_function_setting_a_in, flags_in);
      term_ff[1] <= term_level(output_function_setting_b_in, flags_in);
      term_ff[2] <= term_level(output_function_setting_c_in, flags_in);
    end
  end

  assign terminal_out = term_ff;

endmodule : ppc_term_map

// ===== tb.sv
// testbench: settings-driven checks of the process loop control block
`timescale 1ns/1ps
module tb
  import ppc_pkg::*;
;
  localparam int      TCK = 10;
  logic               ref_clk_in = 1'b0;
  logic               rst_in     = 1'b1;
  ppc_cfg_t           cfg;
  logic [39:0]        in_fn      = '0;
  logic [4:0]         in_term    = '0;
  logic [4:0]         net_term   = '0;
  logic               net_ctl    = 1'b0;
  logic [15:0]        mv_pct     = '0;
  logic [15:0]        ofreq      = '0;
  logic               forward_indication        = 1'b0;
  logic               run_req    = 1'b0;
  logic [7:0]         fn_a       = '0;
  logic [7:0]         fn_b       = '0;
  logic [7:0]         fn_c       = '0;
  logic [15:0]        t2;
  logic [15:0]        t4;
  logic signed [31:0] manip;
  logic signed [16:0] dev;
  logic [15:0]        sp_o;
  logic [15:0]        mv_o;
  logic               running;
  logic               up;
  logic               lo;
  logic               act;
  logic               susp;
  logic [2:0]         term;
  int                 mismatches   = 0;
  int                 total_checks = 0;
  logic [7:0]         codes [4]    = '{PPC_ACT_OFF, PPC_ACT_LOOP_A, PPC_ACT_LOOP_B, 8'h05};

  always #4 ref_clk_in = ~ref_clk_in;

  ppc_sense_model i_sense (.ref_clk_in(ref_clk_in), .sp_pct_in(PPC_PCT_FULL), .mv_pct_in(mv_pct),
    .mv_current_in(cfg.measured_range_setting == PPC_MV_4_20MA),
    .terminal2_adc_out(t2), .terminal4_adc_out(t4));

  ppc_loop_ctrl #(.TICK_CYC(TCK)) i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cfg_in(cfg),
    .input_function_settings_in(in_fn), .input_terminal_in(in_term), .net_terminal_in(net_term),
    .net_control_in(net_ctl), .terminal2_adc_in(t2), .terminal4_adc_in(t4), .output_freq_in(ofreq),
    .forward_indication_in(forward_indication), .reverse_indication_in(!forward_indication), .run_request_in(run_req),
    .output_function_setting_a_in(fn_a), .output_function_setting_b_in(fn_b),
    .output_function_setting_c_in(fn_c), .manipulated_out(manip), .deviation_out(dev),
    .setpoint_pct_out(sp_o), .measured_pct_out(mv_o), .loop_in_effect_out(), .running_out(running),
    .upper_limit_flag_out(up), .lower_limit_flag_out(lo), .rotation_direction_output_out(),
    .loop_active_output_out(act), .suspend_indicator_out(susp), .terminal_out(term));

  // =====
  // tasks
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : settle

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : check

  task automatic sel_case(input logic [7:0] f, input logic [4:0] it, input logic [4:0] nt,
                          input logic nc, input logic e);
    @(posedge ref_clk_in);
    in_fn[7:0] <= f;
    in_term <= it;
    net_term <= nt;
    net_ctl <= nc;
    settle(8);
    check(act, e, "loop selection");
  endtask : sel_case

  task automatic mv_case(input logic [7:0] r, input logic [15:0] p);
    @(posedge ref_clk_in);
    cfg.measured_range_setting <= r;
    mv_pct <= p;
    settle(8);
    check(mv_o, p, "measured percent");
  endtask : mv_case

  task automatic dir_case(input logic [7:0] c, input logic [15:0] p, input logic neg);
    @(posedge ref_clk_in);
    cfg.action_select_setting <= c;
    mv_pct <= p;
    settle(40);
    check($unsigned(dev), 17'(17'h00258 - {1'b0, p}), "deviation");
    check({manip[31], manip == 0}, {neg, 1'b0}, "manipulated sign");
  endtask : dir_case

  task automatic term_case(input logic [7:0] ca, input logic [7:0] cb, input logic [2:0] e);
    @(posedge ref_clk_in);
    fn_a <= ca;
    fn_b <= cb;
    fn_c <= ca;
    settle(8);
    check(term, e, "terminal levels");
  endtask : term_case

  // =====
  // main sequence
  initial
  begin
    cfg = '0;
    cfg.stored_setpoint_value = 16'h01f4;
    cfg.upper_limit_setting = PPC_SENTINEL;
    cfg.lower_limit_setting = PPC_SENTINEL;
    cfg.suspend_detection_time = PPC_SENTINEL;
    cfg.thermistor_protection_level = PPC_SENTINEL;
    cfg.measured_range_setting = PPC_MV_10V;
    cfg.gain_p = 16'h0001;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    foreach (codes[i])
    begin
      @(posedge ref_clk_in);
      cfg.action_select_setting <= codes[i];
      settle(8);
      check(act, codes[i] inside {PPC_ACT_LOOP_A, PPC_ACT_LOOP_B}, "action code");
    end
    @(posedge ref_clk_in);
    cfg.action_select_setting <= PPC_ACT_LOOP_A;
    sel_case(PPC_IN_LOOPSEL, 5'h00, 5'h00, 1'b0, 1'b0);
    sel_case(PPC_IN_LOOPSEL, 5'h1f, 5'h00, 1'b0, 1'b1);
    sel_case(PPC_IN_LOOPSEL, 5'h1f, 5'h00, 1'b1, 1'b0);
    sel_case(PPC_IN_LOOPSEL, 5'h00, 5'h1f, 1'b1, 1'b1);
    sel_case(8'h00, 5'h00, 5'h00, 1'b0, 1'b1);
    check(sp_o, 16'h01f4, "stored set point");
    @(posedge ref_clk_in);
    cfg.stored_setpoint_value <= PPC_SENTINEL;
    settle(8);
    check(sp_o, PPC_PCT_FULL, "terminal set point");
    @(posedge ref_clk_in);
    cfg.setpoint_range_setting <= PPC_SP_10V_B;
    settle(8);
    check(sp_o, PPC_PCT_FULL, "terminal set point alt");
    @(posedge ref_clk_in);
    cfg.thermistor_protection_level <= 16'h0000;
    settle(8);
    check(sp_o, 16'h0000, "thermistor blocks terminal");
    @(posedge ref_clk_in);
    cfg.thermistor_protection_level <= PPC_SENTINEL;
    cfg.stored_setpoint_value <= 16'h0258;
    mv_case(PPC_MV_10V, PPC_PCT_FULL);
    mv_case(PPC_MV_4_20MA, 16'h0000);
    mv_case(PPC_MV_4_20MA, PPC_PCT_FULL);
    mv_case(PPC_MV_10V, 16'h0000);
    dir_case(PPC_ACT_LOOP_A, 16'h0000, 1'b0);
    dir_case(PPC_ACT_LOOP_B, 16'h0000, 1'b1);
    dir_case(PPC_ACT_LOOP_B, PPC_PCT_FULL, 1'b0);
    dir_case(PPC_ACT_LOOP_A, PPC_PCT_FULL, 1'b1);
    @(posedge ref_clk_in);
    cfg.upper_limit_setting <= 16'h01f4;
    cfg.lower_limit_setting <= 16'h01f4;
    settle(8);
    check({up, lo}, 2'b10, "upper flag");
    term_case(PPC_OUT_UPPER, PPC_OUT_LOWER + PPC_NEG_BASE, 3'b111);
    @(posedge ref_clk_in);
    mv_pct <= 16'h0000;
    settle(8);
    check({up, lo}, 2'b01, "lower flag");
    term_case(PPC_OUT_LOWER, PPC_OUT_UPPER + PPC_NEG_BASE, 3'b111);
    @(posedge ref_clk_in);
    cfg.action_select_setting <= PPC_ACT_OFF;
    settle(8);
    check({up, lo, act}, 3'b000, "flags without loop code");
    term_case(PPC_OUT_ACTIVE, PPC_OUT_ACTIVE + PPC_NEG_BASE, 3'b010);
    @(posedge ref_clk_in);
    cfg.action_select_setting <= PPC_ACT_LOOP_A;
    cfg.lower_limit_setting <= PPC_SENTINEL;
    settle(8);
    check(lo, 1'b0, "lower sentinel");
    term_case(PPC_OUT_ACTIVE, PPC_OUT_ACTIVE + PPC_NEG_BASE, 3'b101);
    @(posedge ref_clk_in);
    forward_indication <= 1'b1;
    term_case(PPC_OUT_DIR, PPC_OUT_DIR + PPC_NEG_BASE, 3'b101);
    @(posedge ref_clk_in);
    forward_indication <= 1'b0;
    term_case(PPC_OUT_DIR, PPC_OUT_DIR + PPC_NEG_BASE, 3'b010);
    term_case(PPC_OUT_SUSP, PPC_OUT_SUSP + PPC_NEG_BASE, 3'b010);
    @(posedge ref_clk_in);
    run_req <= 1'b1;
    cfg.suspend_frequency_level <= 16'h0064;
    cfg.suspend_detection_time <= 16'h0001;
    settle(900);
    check({susp, running}, 2'b01, "early suspend");
    settle(200);
    check({susp, running, act, term}, 6'b101101, "suspended");
    @(posedge ref_clk_in);
    ofreq <= 16'h0064;
    settle(8);
    check({susp, running}, 2'b01, "resume");
    @(posedge ref_clk_in);
    ofreq <= 16'h0000;
    cfg.suspend_detection_time <= PPC_SENTINEL;
    settle(1500);
    check(susp, 1'b0, "suspend disabled");
    conclude();
  end

  initial
  begin
    repeat (10000) @(posedge ref_clk_in);
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : tb
